// file: crs_top.sv
// crs_top: datapath for rotate, subtract-from-literal and sleep,
// with the working register, status bits, file registers and watchdog
// counters behind an APB slave.
// assumes: single pclk domain; wake_pin is asynchronous.
`default_nettype none

module crs_top
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power
    input  wire logic        wake_pin,
    output logic             osc_run
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [127:0][7:0] file;
        logic [7:0]        w;
        logic              c;
        logic              nc;
        logic              z;
        logic              pdn;
        logic              tmo;
        crs_mode_e         mode;
        logic [7:0]        wdt;
        logic [7:0]        pre;
        logic [3:0]        div;
        logic [2:0]        sync;
        logic [31:0]       rdata;
        logic              err;
    } crs_state_s;

    crs_state_s st;
    crs_state_s next_st;

    logic [1:0] ctl_op;
    logic       ctl_dest;
    logic [6:0] ctl_addr;
    logic [7:0] ctl_lit;
    logic [7:0] rot_src;
    logic [7:0] rot_res;
    logic       rot_cout;
    logic [7:0] sub_res;
    logic       sub_c;
    logic       sub_nc;
    logic       sub_z;
    logic       setup;
    logic       ack;
    logic       is_file;
    logic       hit;
    logic       exec;
    logic       tick;

    // -----------------------------------------------------------------
    // operand decode and arithmetic
    // -----------------------------------------------------------------
    assign ctl_op   = pwdata[CT_OP_LSB +: 2];
    assign ctl_dest = pwdata[CT_DEST_BIT];
    assign ctl_addr = pwdata[CT_ADDR_LSB +: 7];
    assign ctl_lit  = pwdata[CT_LIT_LSB +: 8];
    assign rot_src  = st.file[ctl_addr];

    crs_rotate u_rot (
        .src       (rot_src),
        .carry_in  (st.c),
        .left      (ctl_op == OP_ROTATE_LEFT_VIA_CARRY),
        .result    (rot_res),
        .carry_out (rot_cout)
    );

    crs_sub u_sub (
        .literal      (ctl_lit),
        .work         (st.w),
        .diff         (sub_res),
        .carry        (sub_c),
        .nibble_carry (sub_nc),
        .zero         (sub_z)
    );

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    assign setup   = psel & ~penable;
    assign ack     = psel & penable;
    assign is_file = (paddr[11:9] == FILE_PAGE) & (paddr[1:0] == 2'h0);
    assign hit     = is_file | (paddr == OFF_CTRL) | (paddr == OFF_WORK)
                   | (paddr == OFF_STAT) | (paddr == OFF_WDT);
    assign exec    = ack & pwrite & (paddr == OFF_CTRL) & ~st.err;
    assign tick    = st.div == 4'(TICK_CYC - 1);

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.sync = {st.sync[1:0], wake_pin};
        next_st.div  = tick ? 4'h0 : st.div + 4'h1;
        if (tick) begin
            next_st.pre = st.pre + 8'h01;
            if (st.pre == 8'hff) begin
                next_st.wdt = st.wdt + 8'h01;
            end
        end
        if (setup) begin
            next_st.rdata = 32'h0;
            // execution refused while the oscillator is stopped
            next_st.err   = ~hit | (pwrite & (paddr == OFF_CTRL)
                          & (st.mode == CRS_SLEEP));
            if (is_file) begin
                next_st.rdata[7:0] = st.file[paddr[8:2]];
            end else begin
                case (paddr)
                    OFF_WORK: next_st.rdata[7:0] = st.w;
                    OFF_STAT: begin
                        next_st.rdata[ST_C]   = st.c;
                        next_st.rdata[ST_NC]  = st.nc;
                        next_st.rdata[ST_Z]   = st.z;
                        next_st.rdata[ST_PDN] = st.pdn;
                        next_st.rdata[ST_TMO] = st.tmo;
                        next_st.rdata[ST_SLP] = st.mode == CRS_SLEEP;
                    end
                    OFF_WDT: begin
                        next_st.rdata[7:0]              = st.wdt;
                        next_st.rdata[WD_PRE_LSB +: 8] = st.pre;
                    end
                    default: next_st.rdata = 32'h0;
                endcase
            end
        end
        if (ack & pwrite & ~st.err) begin
            if (is_file) begin
                next_st.file[paddr[8:2]] = pwdata[7:0];
            end else begin
                case (paddr)
                    OFF_WORK: next_st.w = pwdata[7:0];
                    OFF_STAT: begin
                        next_st.c  = pwdata[ST_C];
                        next_st.nc = pwdata[ST_NC];
                        next_st.z  = pwdata[ST_Z];
                    end
                    default: next_st.w = next_st.w;
                endcase
            end
        end
        if (exec) begin
            case (ctl_op)
                OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY: begin
                    next_st.c = rot_cout;
                    if (ctl_dest) begin
                        next_st.file[ctl_addr] = rot_res;
                    end else begin
                        next_st.w = rot_res;
                    end
                end
                OP_LITERAL_MINUS_WORK: begin
                    next_st.w  = sub_res;
                    next_st.c  = sub_c;
                    next_st.nc = sub_nc;
                    next_st.z  = sub_z;
                end
                default: begin
                    next_st.pdn  = 1'h0;
                    next_st.tmo  = 1'h1;
                    next_st.wdt  = 8'h00;
                    next_st.pre  = 8'h00;
                    next_st.div  = 4'h0;
                    next_st.mode = CRS_SLEEP;
                end
            endcase
        end
        if ((st.mode == CRS_SLEEP) & st.sync[1] & st.sync[2]) begin
            next_st.mode = CRS_RUN;
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.pdn  <= RST_PDN;
            st.tmo  <= RST_TMO;
            st.mode <= CRS_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.rdata;
    assign pready  = 1'h1;
    assign pslverr = ack & st.err;
    assign osc_run = st.mode == CRS_RUN;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ROT_LEFT: assert property (
        exec && ctl_op == OP_ROTATE_LEFT_VIA_CARRY && !ctl_dest
        |=> st.w == {$past(rot_src[6:0]), $past(st.c)}
            && st.c == $past(rot_src[7]) && st.z == $past(st.z)
            && st.nc == $past(st.nc))
        else $error("rotate left result or carry wrong");

    AST_ROT_DEST: assert property (
        exec && ctl_op == OP_ROTATE_LEFT_VIA_CARRY && ctl_dest
        |=> st.w == $past(st.w)
            && st.file[$past(ctl_addr)]
               == {$past(rot_src[6:0]), $past(st.c)})
        else $error("rotate destination wrong");

    AST_ROT_RIGHT: assert property (
        exec && ctl_op == OP_ROTATE_RIGHT_VIA_CARRY && !ctl_dest
        |=> st.w == {$past(st.c), $past(rot_src[7:1])}
            && st.c == $past(rot_src[0]) && st.z == $past(st.z))
        else $error("rotate right result or carry wrong");

    AST_ROT_RDEST: assert property (
        exec && ctl_op == OP_ROTATE_RIGHT_VIA_CARRY && ctl_dest
        |=> st.w == $past(st.w) && st.c == $past(rot_src[0])
            && st.file[$past(ctl_addr)]
               == {$past(st.c), $past(rot_src[7:1])})
        else $error("rotate right destination wrong");

    AST_SLEEP_FLAGS: assert property (
        exec && ctl_op == OP_SLEEP
        |=> !st.pdn && st.tmo && st.c == $past(st.c)
            && st.z == $past(st.z))
        else $error("sleep status bits wrong");

    AST_SLEEP_WDT: assert property (
        exec && ctl_op == OP_SLEEP |=> st.wdt == 8'h00 && st.pre == 8'h00)
        else $error("sleep did not clear watchdog");

    AST_SLEEP_HALT: assert property (
        exec && ctl_op == OP_SLEEP |=> !osc_run ##1 !osc_run)
        else $error("oscillator not halted by sleep");

    AST_SLEEP_REFUSE: assert property (
        setup && pwrite && paddr == OFF_CTRL && !osc_run
        ##1 ack |-> pslverr ##1 st.w == $past(st.w, 2))
        else $error("instruction executed while asleep");

    AST_SUB_RESULT: assert property (
        exec && ctl_op == OP_LITERAL_MINUS_WORK
        |=> st.w == 8'($past(ctl_lit) - $past(st.w)))
        else $error("subtract result wrong");

    AST_SUB_CARRY: assert property (
        exec && ctl_op == OP_LITERAL_MINUS_WORK
        |=> st.c == ($past(st.w) <= $past(ctl_lit))
            && st.nc == ($past(st.w[3:0]) <= $past(ctl_lit[3:0])))
        else $error("subtract carry flags wrong");

    AST_SUB_ZERO: assert property (
        exec && ctl_op == OP_LITERAL_MINUS_WORK
        |=> st.z == ($past(ctl_lit) == $past(st.w)))
        else $error("subtract zero flag wrong");

    AST_REFUSE_MAP: assert property (
        setup && !hit ##1 ack |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    AST_WAKE_SYNC: assert property (
        !osc_run && !(st.sync[1] && st.sync[2]) |=> !osc_run)
        else $error("woke without synchronised wake pin");

    COV_ROT_FILE: cover property (
        exec && ctl_op == OP_ROTATE_RIGHT_VIA_CARRY && ctl_dest);
    COV_SUB_ZERO: cover property (
        exec && ctl_op == OP_LITERAL_MINUS_WORK && sub_z);
    COV_SLEEP_WAKE: cover property (
        exec && ctl_op == OP_SLEEP ##[1:50] osc_run);
    COV_REFUSED: cover property (
        ack && pslverr);

endmodule

`default_nettype wire

// file: crs_pkg.sv
// crs_pkg: constants and types for the rotate / subtract / sleep datapath.
// assumes: 10 MHz pclk, APB3 slave with 32-bit data, 12-bit address.
`default_nettype none

package crs_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_WORK  = 12'h004;
    localparam logic [11:0] OFF_STAT  = 12'h008;
    localparam logic [11:0] OFF_WDT   = 12'h00c;
    localparam logic [2:0]  FILE_PAGE = 3'h1;

    // -----------------------------------------------------------------
    // control word fields
    // -----------------------------------------------------------------
    localparam int CT_OP_LSB   = 0;
    localparam int CT_DEST_BIT = 7;
    localparam int CT_LIT_LSB  = 8;
    localparam int CT_ADDR_LSB = 16;

    // -----------------------------------------------------------------
    // status word fields and reset values
    // -----------------------------------------------------------------
    localparam int ST_C   = 0;
    localparam int ST_NC  = 1;
    localparam int ST_Z   = 2;
    localparam int ST_PDN = 3;
    localparam int ST_TMO = 4;
    localparam int ST_SLP = 5;
    localparam int WD_PRE_LSB = 8;

    localparam logic RST_PDN = 1'h1;
    localparam logic RST_TMO = 1'h1;

    // -----------------------------------------------------------------
    // operations
    // -----------------------------------------------------------------
    localparam logic [1:0] OP_ROTATE_LEFT_VIA_CARRY  = 2'h0;
    localparam logic [1:0] OP_ROTATE_RIGHT_VIA_CARRY = 2'h1;
    localparam logic [1:0] OP_LITERAL_MINUS_WORK     = 2'h2;
    localparam logic [1:0] OP_SLEEP                  = 2'h3;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_NS   = 100;
    localparam int TICK_NS  = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    typedef enum logic {CRS_RUN, CRS_SLEEP} crs_mode_e;

endpackage

`default_nettype wire

// file: crs_rotate.sv
// crs_rotate: one-bit rotate of a byte through the carry.
// assumes: caller picks direction and owns carry storage.
`default_nettype none

module crs_rotate
    import crs_pkg::*;
(
    // operands
    input  wire logic [7:0] src,
    input  wire logic       carry_in,
    input  wire logic       left,
    // result
    output logic      [7:0] result,
    output logic            carry_out
);

    // -----------------------------------------------------------------
    // rotate
    // -----------------------------------------------------------------
    always_comb begin
        if (left) begin
            result    = {src[6:0], carry_in};
            carry_out = src[7];
        end else begin
            result    = {carry_in, src[7:1]};
            carry_out = src[0];
        end
    end

endmodule

`default_nettype wire

// file: crs_sub.sv
// crs_sub: literal minus work register with borrow-style flags.
// assumes: operands are stable for the cycle they are used.
`default_nettype none

module crs_sub
    import crs_pkg::*;
(
    // operands
    input  wire logic [7:0] literal,
    input  wire logic [7:0] work,
    // result
    output logic      [7:0] diff,
    output logic            carry,
    output logic            nibble_carry,
    output logic            zero
);

    // -----------------------------------------------------------------
    // two's complement difference and flags
    // -----------------------------------------------------------------
    always_comb begin
        diff         = literal + ~work + 8'h01;
        carry        = work <= literal;
        nibble_carry = work[3:0] <= literal[3:0];
        zero         = diff == 8'h00;
    end

endmodule

`default_nettype wire

// file: crs_apb_host.sv
// crs_apb_host: apb master model standing in for the core's decoder.
// assumes: one pclk domain; slave answers through pready.
`default_nettype none

module crs_apb_host (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master side
    output logic      [11:0] paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        paddr = 12'h000;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        pwdata = 32'h0;
    end

    // -----------------------------------------------------------------
    // one transfer; paddr and pwdata are left at the inverse of the last value
    // -----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic ok);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        ok = pready;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule

`default_nettype wire

// file: tb_top.sv
// tb_top: self-checking bench for the rotate / subtract / sleep block.
// assumes: crs_pkg register map; apb master in crs_apb_host.
`default_nettype none

module tb_top
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk;
    logic        presetn;
    logic        wake_pin;
    wire  [11:0] paddr;
    wire         psel;
    wire         penable;
    wire         pwrite;
    wire  [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         osc_run;
    int          err_count;
    int          tests_run;

    crs_top crs_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pin(wake_pin), .osc_run(osc_run));
    crs_apb_host crs_apb_host_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial pclk = 1'h0;
    always #50 pclk = ~pclk;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] stw(input int c, nc, z, pdn, tmo, s);
        stw = 32'h0;
        stw[ST_C] = c[0];
        stw[ST_NC] = nc[0];
        stw[ST_Z] = z[0];
        stw[ST_PDN] = pdn[0];
        stw[ST_TMO] = tmo[0];
        stw[ST_SLP] = s[0];
    endfunction

    function automatic logic [31:0] cw(input logic [1:0] op,
                                       input int d, k, f);
        cw = 32'h0;
        cw[CT_OP_LSB +: 2] = op;
        cw[CT_DEST_BIT] = d[0];
        cw[CT_LIT_LSB +: 8] = k[7:0];
        cw[CT_ADDR_LSB +: 7] = f[6:0];
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e, ok;
        crs_apb_host_i.xfer(1'h1, a, d, r, e, ok);
        chk("write answer", 32'h1, {30'h0, e, ok});
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e, ok;
        crs_apb_host_i.xfer(1'h0, a, 32'h0, r, e, ok);
        chk("read answer", 32'h1, {30'h0, e, ok});
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic rot(input logic [1:0] op, input int d, n,
                       input logic [7:0] f, input logic ci);
        logic [7:0] res;
        logic co, lf;
        logic [31:0] r;
        lf = (op == OP_ROTATE_LEFT_VIA_CARRY);
        res = lf ? {f[6:0], ci} : {ci, f[7:1]};
        co = lf ? f[7] : f[0];
        wr({FILE_PAGE, n[6:0], 2'h0}, {24'h0, f});
        wr(OFF_STAT, stw(ci, 1, 1, 0, 0, 0));
        wr(OFF_WORK, 32'h5a);
        wr(OFF_CTRL, cw(op, d, 0, n));
        rd(OFF_WORK, r);
        chk("work", {24'h0, d ? 8'h5a : res}, r);
        rd({FILE_PAGE, n[6:0], 2'h0}, r);
        chk("file", {24'h0, d ? res : f}, r);
        rd(OFF_STAT, r);
        chk("rot flags", stw(co, 1, 1, RST_PDN, RST_TMO, 0), r);
    endtask

    task automatic sub(input logic [7:0] k, w);
        logic [7:0] df;
        logic c, nc, z;
        logic [31:0] r;
        df = k - w;
        c = (w <= k);
        nc = (w[3:0] <= k[3:0]);
        z = (df == 8'h00);
        wr(OFF_STAT, stw(!c, !nc, !z, 0, 0, 0));
        wr(OFF_WORK, {24'h0, w});
        wr(OFF_CTRL, cw(OP_LITERAL_MINUS_WORK, 0, k, 0));
        rd(OFF_WORK, r);
        chk("difference", {24'h0, df}, r);
        rd(OFF_STAT, r);
        chk("sub flags", stw(c, nc, z, RST_PDN, RST_TMO, 0), r);
    endtask

    task automatic t_refuse();
        logic [31:0] r;
        logic e, ok;
        crs_apb_host_i.xfer(1'h0, 12'h010, 32'h0, r, e, ok);
        chk("unmapped refused", 32'h3, {30'h0, e, ok});
        chk("unmapped data", 32'h0, r);
        crs_apb_host_i.xfer(1'h1, 12'h201, 32'h77, r, e, ok);
        chk("misaligned refused", 32'h3, {30'h0, e, ok});
        rd({FILE_PAGE, 7'h00, 2'h0}, r);
        chk("file kept", 32'h0, r);
    endtask

    task automatic t_sleep();
        logic [31:0] r;
        logic e, ok;
        int n;
        repeat (300) @(posedge pclk);
        rd(OFF_WDT, r);
        chk("wdt running", 32'h1, {31'h0, r != 32'h0});
        wr(OFF_STAT, stw(1, 0, 1, 0, 0, 0));
        wr(OFF_WORK, 32'h33);
        wr(OFF_CTRL, cw(OP_SLEEP, 0, 0, 0));
        rd(OFF_WDT, r);
        chk("wdt cleared", 32'h0, r);
        rd(OFF_STAT, r);
        chk("sleep status", stw(1, 0, 1, 0, 1, 1), r);
        chk("osc stopped", 32'h0, {31'h0, osc_run});
        crs_apb_host_i.xfer(1'h1, OFF_CTRL,
            cw(OP_LITERAL_MINUS_WORK, 0, 0, 0), r, e, ok);
        chk("ctrl refused", 32'h3, {30'h0, e, ok});
        rd(OFF_WORK, r);
        chk("work held", 32'h33, r);
        wake_pin <= 1'h1;
        n = 0;
        while (osc_run !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        wake_pin <= 1'h0;
        chk("osc woken", 32'h1, {31'h0, osc_run});
        rd(OFF_STAT, r);
        chk("woken status", stw(1, 0, 1, 0, 1, 0), r);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(3000 * CLK_NS);
        err_count++;
        print_verdict();
    end

    initial begin
        logic [31:0] r;
        err_count = 0;
        tests_run = 0;
        presetn = 1'h0;
        wake_pin = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        rd(OFF_STAT, r);
        chk("reset status", stw(0, 0, 0, RST_PDN, RST_TMO, 0), r);
        rot(OP_ROTATE_LEFT_VIA_CARRY, 0, 5, 8'he6, 1'h0);
        rot(OP_ROTATE_LEFT_VIA_CARRY, 1, 127, 8'h80, 1'h1);
        rot(OP_ROTATE_RIGHT_VIA_CARRY, 1, 0, 8'h01, 1'h0);
        rot(OP_ROTATE_RIGHT_VIA_CARRY, 0, 64, 8'h02, 1'h1);
        t_refuse();
        sub(8'h05, 8'h05);
        sub(8'h03, 8'h04);
        sub(8'h10, 8'h01);
        sub(8'hff, 8'h00);
        sub(8'h00, 8'hff);
        t_sleep();
        print_verdict();
    end
endmodule

`default_nettype wire
